//--- design/ccpu_top.sv
// Two capture/compare/PWM channels behind an AXI4-Lite register slave.
`timescale 1ns/1ps
module ccpu_top (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register bus.
  input wire ccpu_pkg::ccpu_axi_req_type axi_req_in,
  output ccpu_pkg::ccpu_axi_rsp_type axi_rsp_out,
  // Channel pins.
  input wire logic [1:0] capture_pin_in,
  output logic [1:0] channel_pin_out,
  // Sixteen-bit timer.
  input wire logic [15:0] sixteen_bit_timer_in,
  output logic timer_reset_out,
  output logic timer_overflow_block_out,
  // Eight-bit timer and period.
  input wire logic [7:0] eight_bit_timer_in,
  input wire logic [7:0] pwm_period_in,
  input wire logic timer_increment_in,
  input wire logic [1:0] phase_bits_in,
  output logic eight_bit_timer_clear_out,
  // Converter.
  input wire logic converter_enable_in,
  output logic converter_start_out
);
  import ccpu_pkg::*;

  // ==========================================================================
  // Helper functions.
  // ==========================================================================
  // Map a byte address to a register select code.
  function automatic logic [3:0] decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (idx == {22'h000000, IDX_FLAG1}) decode = SEL_FLAG1;
    else if (idx == {22'h000000, IDX_FLAG2}) decode = SEL_FLAG2;
    else if (idx == {22'h000000, IDX_LOW1}) decode = SEL_LOW1;
    else if (idx == {22'h000000, IDX_HIGH1}) decode = SEL_HIGH1;
    else if (idx == {22'h000000, IDX_CTRL1}) decode = SEL_CTRL1;
    else if (idx == {22'h000000, IDX_LOW2}) decode = SEL_LOW2;
    else if (idx == {22'h000000, IDX_HIGH2}) decode = SEL_HIGH2;
    else if (idx == {22'h000000, IDX_CTRL2}) decode = SEL_CTRL2;
    else decode = SEL_NONE;
  endfunction : decode

  // Mode group of a control byte.
  function automatic logic [1:0] group_of(input logic [7:0] ctrl);
    group_of = ctrl[MODE_MSB -: 2];
  endfunction : group_of

  // ==========================================================================
  // AXI4-Lite write path.
  // ==========================================================================
  logic aw_held;
  logic [31:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic b_valid;
  logic [1:0] b_resp;
  wire aw_take = axi_req_in.awvalid && !aw_held && !b_valid;
  wire w_take = axi_req_in.wvalid && !w_held && !b_valid;
  wire do_write = aw_held && w_held && !b_valid;
  wire [3:0] wr_sel = decode(aw_addr);
  // Only byte lane 0 carries the eight-bit registers.
  wire wr_en = do_write && w_strb[0];
  wire [7:0] wr_byte = w_data[7:0];

  // Address and data are held separately so either may arrive first.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= axi_req_in.awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= axi_req_in.wdata;
        w_strb <= axi_req_in.wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; an unmapped address answers with a slave error.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      b_valid <= 1'b0;
      b_resp <= RESP_OKAY;
    end else if (do_write) begin
      b_valid <= 1'b1;
      b_resp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (b_valid && axi_req_in.bready) begin
      b_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Channel state arrays.
  // ==========================================================================
  logic [7:0] ctrl [2];
  logic [7:0] val_low [2];
  logic [7:0] val_high [2];
  logic [1:0] duty_latch [2];
  logic flag [2];
  logic out_latch [2];
  logic [2:0] pin_sync [2];
  logic [3:0] presc [2];
  logic match_q [2];
  logic trig_q [2];

  // Shared period end for both channels of the eight-bit timer base.
  wire period_end = timer_increment_in &&
    (eight_bit_timer_in == pwm_period_in);

  // ==========================================================================
  // Per channel logic.
  // ==========================================================================
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire [3:0] mode = ctrl[ch][MODE_MSB:0];
    wire [1:0] grp = group_of(ctrl[ch]);
    wire is_off = (mode == MODE_OFF);
    wire is_cap = (grp == GROUP_CAPTURE);
    wire is_cmp = (grp == GROUP_COMPARE);
    wire is_pwm = (grp == GROUP_PWM);
    wire [3:0] sel_low = (ch == 0) ? SEL_LOW1 : SEL_LOW2;
    wire [3:0] sel_high = (ch == 0) ? SEL_HIGH1 : SEL_HIGH2;
    wire [3:0] sel_ctrl = (ch == 0) ? SEL_CTRL1 : SEL_CTRL2;
    wire [3:0] sel_flag = (ch == 0) ? SEL_FLAG1 : SEL_FLAG2;
    wire [2:0] flag_pos = (ch == 0) ? 3'(FLAG1_BIT) : 3'(FLAG2_BIT);
    // Edge pulses look only at the second and third stages.
    wire rise = pin_sync[ch][1] && !pin_sync[ch][2];
    wire fall = !pin_sync[ch][1] && pin_sync[ch][2];
    wire cap_evt = is_cap && (
      ((mode == MODE_CAP_FALL) && fall) ||
      ((mode == MODE_CAP_RISE) && rise) ||
      ((mode == MODE_CAP_RISE4) && rise &&
        (presc[ch][1:0] == PRESC_LAST4)) ||
      ((mode == MODE_CAP_RISE16) && rise &&
        (presc[ch] == PRESC_LAST16)));
    wire match = is_cmp &&
      (sixteen_bit_timer_in == {val_high[ch], val_low[ch]});
    // One event per match so a stopped timer does not refire every cycle.
    wire cmp_evt = match && !match_q[ch];
    wire [9:0] next_duty = {val_low[ch], ctrl[ch][DUTY_LSB +: 2]};
    // The clear is registered, so it is armed one count early; the pin
    // then drops on the duty count itself and duty n gives n high counts.
    wire [9:0] duty_prev = {val_high[ch], duty_latch[ch]} - 10'h001;
    wire duty_hit = ({eight_bit_timer_in, phase_bits_in} ==
      duty_prev);
    wire pwm_latch = is_pwm && period_end;
    wire flag_wr = wr_en && (wr_sel == sel_flag);

    // Pin synchroniser, three stages for edge detection.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        pin_sync[ch] <= 3'h0;
      end else begin
        pin_sync[ch] <= {pin_sync[ch][1:0], capture_pin_in[ch]};
      end
    end

    // Control register; upper two bits never store.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        ctrl[ch] <= CTRL_RESET;
      end else if (wr_en && (wr_sel == sel_ctrl)) begin
        ctrl[ch] <= wr_byte & CTRL_WMASK;
      end
    end

    // Low byte: capture wins over a software write in the same cycle.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        val_low[ch] <= VALUE_RESET;
      end else if (cap_evt) begin
        val_low[ch] <= sixteen_bit_timer_in[7:0];
      end else if (wr_en && (wr_sel == sel_low)) begin
        val_low[ch] <= wr_byte;
      end
    end

    // High byte doubles as the active duty buffer in PWM mode.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        val_high[ch] <= VALUE_RESET;
        duty_latch[ch] <= 2'h0;
      end else if (cap_evt) begin
        val_high[ch] <= sixteen_bit_timer_in[15:8];
      end else if (pwm_latch) begin
        val_high[ch] <= next_duty[9:2];
        duty_latch[ch] <= next_duty[1:0];
      end else if (wr_en && (wr_sel == sel_high) && !is_pwm) begin
        val_high[ch] <= wr_byte;
      end
    end

    // Prescaler counts rising edges in any capture mode.
    // A direct change of prescale keeps the count running.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in || !is_cap) begin
        presc[ch] <= PRESC_RESET;
      end else if (rise) begin
        presc[ch] <= presc[ch] + 4'h1;
      end
    end

    // Event flag: a hardware set wins over a software clear.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        flag[ch] <= 1'b0;
      end else if (cap_evt || cmp_evt) begin
        flag[ch] <= 1'b1;
      end else if (flag_wr) begin
        flag[ch] <= w_data[flag_pos];
      end
    end

    // Compare/PWM output latch, separate from any port data latch.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in || is_off) begin
        out_latch[ch] <= 1'b0;
      end else if (cmp_evt && (mode == MODE_CMP_HIGH)) begin
        out_latch[ch] <= 1'b1;
      end else if (cmp_evt && (mode == MODE_CMP_LOW)) begin
        out_latch[ch] <= 1'b0;
      end else if (pwm_latch) begin
        out_latch[ch] <= (next_duty != 10'h000);
      end else if (is_pwm && duty_hit) begin
        out_latch[ch] <= 1'b0;
      end
    end

    // Match history and special event pulse, held clear while off.
    always_ff @(posedge clock_in) begin
      if (!rst_n_in || is_off) begin
        match_q[ch] <= 1'b0;
        trig_q[ch] <= 1'b0;
      end else begin
        match_q[ch] <= match;
        trig_q[ch] <= cmp_evt && (mode == MODE_CMP_TRIG);
      end
    end

    assign channel_pin_out[ch] = out_latch[ch];
  end

  // ==========================================================================
  // Timer and converter outputs.
  // ==========================================================================
  // The trigger uses the timer's reset input, not its rollover path.
  assign timer_reset_out = trig_q[0] || trig_q[1];
  assign timer_overflow_block_out = timer_reset_out;
  assign converter_start_out = trig_q[1] && converter_enable_in;
  assign eight_bit_timer_clear_out = period_end;

  // ==========================================================================
  // AXI4-Lite read path.
  // ==========================================================================
  logic r_valid;
  logic [31:0] r_data;
  logic [1:0] r_resp;
  wire ar_take = axi_req_in.arvalid && !r_valid;
  wire [3:0] rd_sel = decode(axi_req_in.araddr);
  logic [7:0] rd_byte;

  // Read selection; the high bits of every word read as zero.
  always_comb begin
    unique case (rd_sel)
      SEL_FLAG1: rd_byte = 8'(flag[0]) << FLAG1_BIT;
      SEL_FLAG2: rd_byte = 8'(flag[1]) << FLAG2_BIT;
      SEL_LOW1: rd_byte = val_low[0];
      SEL_HIGH1: rd_byte = val_high[0];
      SEL_CTRL1: rd_byte = ctrl[0];
      SEL_LOW2: rd_byte = val_low[1];
      SEL_HIGH2: rd_byte = val_high[1];
      SEL_CTRL2: rd_byte = ctrl[1];
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is registered at the edge the address is taken.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      r_valid <= 1'b0;
      r_data <= 32'h00000000;
      r_resp <= RESP_OKAY;
    end else if (ar_take) begin
      r_valid <= 1'b1;
      r_data <= {24'h000000, rd_byte};
      r_resp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (r_valid && axi_req_in.rready) begin
      r_valid <= 1'b0;
    end
  end

  // Bus answers.
  assign axi_rsp_out.awready = !aw_held && !b_valid;
  assign axi_rsp_out.wready = !w_held && !b_valid;
  assign axi_rsp_out.bvalid = b_valid;
  assign axi_rsp_out.bresp = b_resp;
  assign axi_rsp_out.arready = !r_valid;
  assign axi_rsp_out.rvalid = r_valid;
  assign axi_rsp_out.rdata = r_data;
  assign axi_rsp_out.rresp = r_resp;

endmodule : ccpu_top

//--- pkg/ccpu_pkg.sv
// Package with register map, field layout, mode codes and bus carriers.
package ccpu_pkg;

  // ==========================================================================
  // Register indexes; byte address is four times the index.
  // ==========================================================================
  localparam logic [7:0] IDX_FLAG1 = 8'h0c;
  localparam logic [7:0] IDX_FLAG2 = 8'h0d;
  localparam logic [7:0] IDX_LOW1 = 8'h15;
  localparam logic [7:0] IDX_HIGH1 = 8'h16;
  localparam logic [7:0] IDX_CTRL1 = 8'h17;
  localparam logic [7:0] IDX_LOW2 = 8'h1b;
  localparam logic [7:0] IDX_HIGH2 = 8'h1c;
  localparam logic [7:0] IDX_CTRL2 = 8'h1d;

  // ==========================================================================
  // Field positions and reset values.
  // ==========================================================================
  localparam int FLAG1_BIT = 2;
  localparam int FLAG2_BIT = 0;
  localparam int DUTY_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h3f;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [3:0] PRESC_RESET = 4'h0;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;
  localparam logic [1:0] PRESC_LAST4 = 2'h3;

  // ==========================================================================
  // Mode select codes.
  // ==========================================================================
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW = 4'h9;
  localparam logic [3:0] MODE_CMP_FLAG = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] GROUP_CAPTURE = 2'h1;
  localparam logic [1:0] GROUP_COMPARE = 2'h2;
  localparam logic [1:0] GROUP_PWM = 2'h3;

  // ==========================================================================
  // Bus answer codes and register select codes.
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_FLAG1 = 4'h1;
  localparam logic [3:0] SEL_FLAG2 = 4'h2;
  localparam logic [3:0] SEL_LOW1 = 4'h3;
  localparam logic [3:0] SEL_HIGH1 = 4'h4;
  localparam logic [3:0] SEL_CTRL1 = 4'h5;
  localparam logic [3:0] SEL_LOW2 = 4'h6;
  localparam logic [3:0] SEL_HIGH2 = 4'h7;
  localparam logic [3:0] SEL_CTRL2 = 4'h8;

  // ==========================================================================
  // AXI4-Lite carriers.
  // ==========================================================================
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } ccpu_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccpu_axi_rsp_type;

endpackage : ccpu_pkg

//--- tb/ccpu_bench.sv
// Self-checking bench of the capture/compare/PWM unit.
`timescale 1ns/1ps
module ccpu_bench;
  import ccpu_pkg::*;
  // Stimulus, observed outputs and the queue of expected results.
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  ccpu_axi_req_type req = '{wstrb: 4'hf, default: '0};
  ccpu_axi_rsp_type rsp;
  logic [1:0] lv = 2'h0, pins, chpin, ph = 2'h0;
  logic slow = 1'b0, run = 1'b0, probe = 1'b0, inc = 1'b0, ce = 1'b0;
  logic clr, trg, conv;
  logic [15:0] t16 = 16'h0000, seed = 16'h0038;
  logic [7:0] t8 = 8'h00, per = 8'h03, nt = 8'h00, nc = 8'h00;
  logic [7:0] hc = 8'h00, hl = 8'h00;
  logic [33:0] exq[$], e;
  logic [7:0] map [8] = '{IDX_FLAG1, IDX_FLAG2, IDX_LOW1, IDX_HIGH1,
    IDX_CTRL1, IDX_LOW2, IDX_HIGH2, IDX_CTRL2};
  logic [7:0] cm [4] = '{8'h08, 8'h0a, 8'h09, 8'h08};
  int n_errors = 0, samples_checked = 0, j;
  always #10 clock_in = ~clock_in;
  ccpu_top i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .axi_req_in(req), .axi_rsp_out(rsp), .capture_pin_in(pins),
    .channel_pin_out(chpin), .sixteen_bit_timer_in(t16),
    .timer_reset_out(trg), .timer_overflow_block_out(),
    .eight_bit_timer_in(t8), .pwm_period_in(per), .timer_increment_in(inc),
    .phase_bits_in(ph), .eight_bit_timer_clear_out(clr),
    .converter_enable_in(ce), .converter_start_out(conv));
  ccpu_pin_src i_src (.clock_in(clock_in), .level_in(lv), .slow_in(slow),
    .pin_out(pins));
  // ======================
  // Timer model and checking.
  // ======================
  // The eight-bit timer steps every fourth cycle; pin high time is summed
  // per period so duty can be judged without knowing the phase.
  always @(posedge clock_in) begin
    ph <= ph + 2'h1;
    inc <= run && ph == 2'h2;
    if (inc) t8 <= (t8 == per) ? 8'h00 : t8 + 8'h01;
    if (trg) nt <= nt + 8'h01;
    if (conv) nc <= nc + 8'h01;
    hc <= clr ? 8'h00 : hc + {7'h0, chpin[0]};
    if (clr) hl <= hc + {7'h0, chpin[0]};
  end
  // Each bus answer or probe is matched against the oldest note.
  always @(posedge clock_in) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready) ||
        probe) begin
      e = exq.pop_front();
      samples_checked++;
      if (probe ? {nc, nt, hl, 6'h00, chpin} !== e[31:0]
          : rsp.bvalid ? rsp.bresp !== e[33:32]
          : {rsp.rresp, rsp.rdata} !== e) begin
        n_errors++;
        $display("[FAIL] %0t result differs from %h", $time, e);
      end
    end
  end
  // ======================
  // Tasks.
  // ======================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] r = RESP_OKAY);
    int k;
    @(posedge clock_in);
    exq.push_back({r, 32'h0});
    req.awaddr <= {22'h0, i, 2'h0};
    req.wdata <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clock_in);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    if (k == 40) hang();
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] r = RESP_OKAY);
    int k;
    @(posedge clock_in);
    exq.push_back({r, 24'h0, d});
    req.araddr <= {22'h0, i, 2'h0};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clock_in);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    if (k == 40) hang();
  endtask : rd
  task automatic pr(input logic [31:0] x);
    @(posedge clock_in);
    exq.push_back({2'h0, x});
    probe <= 1'b1;
    @(posedge clock_in);
    probe <= 1'b0;
  endtask : pr
  // Long settle time covers synchroniser, edge detect and a slow source.
  task automatic tg(input int c, input logic v);
    @(posedge clock_in);
    lv[c] <= v;
    repeat (9) @(posedge clock_in);
  endtask : tg
  task automatic pul;
    tg(0, 1'b1);
    tg(0, 1'b0);
  endtask : pul
  // Holding the match for several cycles must still give one event only.
  task automatic hit;
    t16 <= seed;
    repeat (5) @(posedge clock_in);
    t16 <= ~seed;
  endtask : hit
  task automatic presc(input logic [7:0] m0, input int pre,
                       input logic [7:0] m, input int n);
    wr(IDX_CTRL1, 8'h00);
    wr(IDX_CTRL1, m0);
    repeat (pre) pul();
    wr(IDX_CTRL1, m);
    wr(IDX_FLAG1, 8'h00);
    repeat (n - 1) pul();
    rd(IDX_FLAG1, 8'h00);
    pul();
    rd(IDX_FLAG1, 8'h04);
  endtask : presc
  task automatic hang;
    n_errors++;
    give_verdict();
  endtask : hang
  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // ======================
  // Main sequence.
  // ======================
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (map[i]) rd(map[i], 8'h00);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(8'h00, 8'h5a, RESP_SLVERR);
    wr(IDX_CTRL1, 8'hc5);
    rd(IDX_CTRL1, 8'h05);
    t16 <= seed;
    tg(0, 1'b1);
    rd(IDX_LOW1, seed[7:0]);
    rd(IDX_HIGH1, seed[15:8]);
    rd(IDX_FLAG1, 8'h04);
    t16 <= lfsr(seed);
    tg(0, 1'b0);
    rd(IDX_LOW1, seed[7:0]);
    seed = lfsr(seed);
    tg(0, 1'b1);
    rd(IDX_LOW1, seed[7:0]);
    rd(IDX_HIGH1, seed[15:8]);
    wr(IDX_FLAG1, 8'h00);
    rd(IDX_FLAG1, 8'h00);
    tg(0, 1'b0);
    slow <= 1'b1;
    wr(IDX_CTRL2, {4'h0, MODE_CAP_FALL});
    seed = lfsr(seed);
    t16 <= seed;
    tg(1, 1'b1);
    rd(IDX_FLAG2, 8'h00);
    tg(1, 1'b0);
    rd(IDX_LOW2, seed[7:0]);
    rd(IDX_HIGH2, seed[15:8]);
    rd(IDX_FLAG2, 8'h01);
    slow <= 1'b0;
    presc(8'h06, 0, 8'h06, 4);
    presc(8'h07, 0, 8'h07, 16);
    presc(8'h06, 2, 8'h07, 14);
    seed = lfsr(seed);
    t16 <= ~seed;
    wr(IDX_CTRL1, 8'h00);
    wr(IDX_LOW1, seed[7:0]);
    wr(IDX_HIGH1, seed[15:8]);
    for (j = 0; j < 4; j++) begin
      wr(IDX_CTRL1, cm[j]);
      wr(IDX_FLAG1, 8'h00);
      hit();
      rd(IDX_FLAG1, 8'h04);
      pr({28'h0, (4'b1011 >> j) & 4'h1});
    end
    wr(IDX_CTRL1, 8'h00);
    pr(32'h00000000);
    wr(IDX_CTRL1, 8'h0b);
    hit();
    pr(32'h00010000);
    wr(IDX_CTRL1, 8'h00);
    wr(IDX_LOW2, seed[7:0]);
    wr(IDX_HIGH2, seed[15:8]);
    wr(IDX_CTRL2, 8'h0b);
    ce <= 1'b1;
    hit();
    pr(32'h01020000);
    ce <= 1'b0;
    hit();
    pr(32'h01030000);
    wr(IDX_CTRL2, 8'h00);
    wr(IDX_LOW1, 8'h02);
    wr(IDX_CTRL1, 8'h1c);
    run <= 1'b1;
    repeat (50) @(posedge clock_in);
    wr(IDX_HIGH1, 8'hff);
    rd(IDX_HIGH1, 8'h02);
    run <= 1'b0;
    wr(IDX_CTRL1, 8'h00);
    pr(32'h01030900);
    give_verdict();
  end
endmodule : ccpu_bench

//--- tb/ccpu_chk.sv
// Port-level assertions for the capture/compare/PWM unit.
`timescale 1ns/1ps
module ccpu_chk (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register bus.
  input wire ccpu_pkg::ccpu_axi_req_type axi_req_in,
  input wire ccpu_pkg::ccpu_axi_rsp_type axi_rsp_out,
  // Timers and events.
  input wire logic [7:0] eight_bit_timer_in,
  input wire logic [7:0] pwm_period_in,
  input wire logic timer_increment_in,
  input wire logic eight_bit_timer_clear_out,
  input wire logic timer_reset_out,
  input wire logic timer_overflow_block_out,
  input wire logic converter_start_out
);
  import ccpu_pkg::*;
  default clocking dcb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // ======================
  // Bus handshake steps.
  // ======================
  // A write is answered once address and data have both been taken.
  sequence s_write_taken;
    axi_req_in.awvalid && axi_rsp_out.awready &&
    axi_req_in.wvalid && axi_rsp_out.wready;
  endsequence
  sequence s_read_taken;
    axi_req_in.arvalid && axi_rsp_out.arready;
  endsequence
  // The write lands one edge after both are taken; bvalid stands after it.
  a_write_answer: assert property (s_write_taken |=> ##1 axi_rsp_out.bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_read_taken |=> axi_rsp_out.rvalid)
    else $error("read response missing");
  a_bresp_holds: assert property (axi_rsp_out.bvalid && !axi_req_in.bready
    |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
    |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read data dropped early");
  a_read_refused: assert property (axi_rsp_out.rvalid
    |-> !axi_rsp_out.arready) else $error("read taken while busy");
  // ======================
  // Timer events.
  // ======================
  // The clear follows the period match within the same cycle.
  a_clear_on_period: assert property (eight_bit_timer_clear_out ==
    (timer_increment_in && eight_bit_timer_in == pwm_period_in))
    else $error("timer clear does not follow period match");
  a_trigger_pulse: assert property (timer_reset_out |=> !timer_reset_out)
    else $error("special event longer than one cycle");
  a_overflow_blocked: assert property (timer_overflow_block_out ==
    timer_reset_out) else $error("overflow block not with trigger");
  a_start_with_trig: assert property (converter_start_out |->
    timer_reset_out) else $error("converter start without trigger");
endmodule : ccpu_chk

bind ccpu_top ccpu_chk i_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out),
  .eight_bit_timer_in(eight_bit_timer_in), .pwm_period_in(pwm_period_in),
  .timer_increment_in(timer_increment_in),
  .eight_bit_timer_clear_out(eight_bit_timer_clear_out),
  .timer_reset_out(timer_reset_out),
  .timer_overflow_block_out(timer_overflow_block_out),
  .converter_start_out(converter_start_out));

//--- tb/ccpu_pin_src.sv
// Signal source model that drives the two capture pins.
`timescale 1ns/1ps
module ccpu_pin_src (
  // Clock.
  input wire logic clock_in,
  // Requested levels and answer speed.
  input wire logic [1:0] level_in,
  input wire logic slow_in,
  // Pins toward the unit.
  output logic [1:0] pin_out
);
  logic [1:0] stage [0:3];
  // Levels move only after an edge; a slow source lags three more cycles.
  always @(posedge clock_in) begin
    stage[0] <= level_in;
    stage[1] <= stage[0];
    stage[2] <= stage[1];
    stage[3] <= stage[2];
  end
  assign pin_out = slow_in ? stage[3] : stage[0];
endmodule : ccpu_pin_src
